/* verilog/fsps_pkg.sv */
package fsps_pkg;
    // Clock and timing
    localparam int unsigned CLOCK_MHZ     = 10;
    localparam int unsigned PROG_TIME_US  = 4000;
    localparam int unsigned WINDOW_CYCLES = 4;
    localparam logic [2:0]  WINDOW_LOAD   = 3'(WINDOW_CYCLES);

    // Register bus map, byte addresses
    localparam int unsigned ADDR_W        = 4;
    localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET = 4'h4;

    // Control register fields and reset value
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_ERASE_BIT  = 1;
    localparam int unsigned CTRL_WRITE_BIT  = 2;
    localparam int unsigned CTRL_FUSE_BIT   = 3;
    localparam int unsigned CTRL_CLEAR_BIT  = 4;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Command patterns in the low five control bits
    localparam logic [4:0] CMD_LOAD  = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_FUSE  = 5'h09;
    localparam logic [4:0] CMD_CLEAR = 5'h11;

    // Status register fields
    localparam int unsigned STAT_BUSY_BIT   = 0;
    localparam int unsigned STAT_ARMED_BIT  = 1;
    localparam int unsigned STAT_LOADED_BIT = 2;
    localparam int unsigned STAT_EEPROM_BIT = 3;

    // Address pointer pair layout
    localparam int unsigned PTR_W      = 16;
    localparam int unsigned WORD_LSB   = 1;
    localparam int unsigned WORD_W     = 5;
    localparam int unsigned PAGE_LSB   = 6;
    localparam int unsigned PAGE_W     = 7;
    localparam int unsigned PAGE_WORDS = 32;
    localparam int unsigned DATA_W     = 16;
    localparam logic [15:0] BUF_CLEAR_WORD = 16'hffff;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ARMED,
        SEQ_ERASE,
        SEQ_WRITE
    } fsps_state_type;
endpackage

/* verilog/fsps_flash_timer.sv */
`timescale 1ns/1ps
module fsps_flash_timer
    import fsps_pkg::*;
#(
    parameter int unsigned CYCLES = PROG_TIME_US * CLOCK_MHZ
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic start,
    output logic      done
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        done_reg;
    logic        done_next;

    // Count down one erase or write duration
    always_comb begin
        count_next = count_reg;
        done_next  = 1'b0;
        if (start) begin
            count_next = CYCLES;
        end else if (count_reg == 32'h1) begin
            count_next = 32'h0;
            done_next  = 1'b1;
        end else if (count_reg != 32'h0) begin
            count_next = count_reg - 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count_reg <= 32'h0;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end

    assign done = done_reg;
endmodule // fsps_flash_timer

/* verilog/fsps_page_buffer.sv */
`timescale 1ns/1ps
module fsps_page_buffer
    import fsps_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              load,
    input  wire logic [WORD_W-1:0] index,
    input  wire logic [DATA_W-1:0] data,
    input  wire logic              clear,
    input  wire logic [WORD_W-1:0] rd_index,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   any_loaded
);
    logic [PAGE_WORDS-1:0][DATA_W-1:0] mem_reg;
    logic [PAGE_WORDS-1:0][DATA_W-1:0] mem_next;
    logic [PAGE_WORDS-1:0]             valid_reg;
    logic [PAGE_WORDS-1:0]             valid_next;
    logic [DATA_W-1:0]                 rd_data_reg;
    logic [DATA_W-1:0]                 rd_data_next;

    // Per entry: clear wins, else a matching load stores the word
    for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_entry
        localparam logic [WORD_W-1:0] ENTRY = WORD_W'(i);
        assign mem_next[i]   = clear ? BUF_CLEAR_WORD :
                               (load && index == ENTRY) ? data : mem_reg[i];
        assign valid_next[i] = clear ? 1'b0 : ((load && index == ENTRY) || valid_reg[i]);
    end

    // Read port toward the flash array
    always_comb begin
        rd_data_next = mem_reg[rd_index];
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mem_reg     <= {PAGE_WORDS{BUF_CLEAR_WORD}};
            valid_reg   <= '0;
            rd_data_reg <= BUF_CLEAR_WORD;
        end else begin
            mem_reg     <= mem_next;
            valid_reg   <= valid_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data    = rd_data_reg;
    assign any_loaded = |valid_reg;
endmodule // fsps_page_buffer

/* verilog/fsps_sequencer.sv */
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fsps_sequencer
    import fsps_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_TIME_US * CLOCK_MHZ
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              store_program_instruction,
    input  wire logic [PTR_W-1:0]  pointer_pair,
    input  wire logic [DATA_W-1:0] data_register_pair,
    input  wire logic              eeprom_write_busy,
    output logic                   core_halt,
    output logic                   flash_erase_start,
    output logic                   flash_write_start,
    output logic      [PAGE_W-1:0] flash_page,
    input  wire logic [WORD_W-1:0] flash_rd_index,
    output logic      [DATA_W-1:0] flash_rd_data
);
    // Bus slave state
    logic        wait_reg;
    logic        wait_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;

    // Sequencer state
    fsps_state_type    state_reg;
    fsps_state_type    state_next;
    logic [7:0]        ctrl_reg;
    logic [7:0]        ctrl_next;
    logic [2:0]        window_reg;
    logic [2:0]        window_next;
    logic [PAGE_W-1:0] page_reg;
    logic [PAGE_W-1:0] page_next;
    logic              halt_reg;
    logic              halt_next;
    logic              erase_start_reg;
    logic              erase_start_next;
    logic              write_start_reg;
    logic              write_start_next;

    // Decoded strobes
    logic              bus_write;
    logic              ctrl_write;
    logic [4:0]        cmd;
    logic              cmd_valid;
    logic              seq_busy;
    logic              ctrl_accept;
    logic              buf_load;
    logic              buf_clear;
    logic [WORD_W-1:0] buf_index;
    logic              buf_any_loaded;
    logic              timer_start;
    logic              timer_done;
    logic [PAGE_W-1:0] ptr_page;

    // One wait state per access, transfer ends when waitrequest is low
    always_comb begin
        wait_next     = !((avs_read || avs_write) && wait_reg);
        readdata_next = readdata_reg;
        if (avs_read && wait_reg) begin
            if (avs_address == CTRL_OFFSET) begin
                readdata_next = {24'h0, ctrl_reg};
            end else if (avs_address == STATUS_OFFSET) begin
                readdata_next = 32'h0;
                readdata_next[STAT_BUSY_BIT]   = seq_busy;
                readdata_next[STAT_ARMED_BIT]  = (state_reg == SEQ_ARMED);
                readdata_next[STAT_LOADED_BIT] = buf_any_loaded;
                readdata_next[STAT_EEPROM_BIT] = eeprom_write_busy;
            end else begin
                readdata_next = 32'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wait_reg     <= 1'b1;
            readdata_reg <= 32'h0;
        end else begin
            wait_reg     <= wait_next;
            readdata_reg <= readdata_next;
        end
    end

    // Command decode from the control register write
    assign bus_write  = avs_write && !wait_reg;
    assign ctrl_write = bus_write && (avs_address == CTRL_OFFSET) && avs_byteenable[0];
    assign cmd        = avs_writedata[4:0];
    assign cmd_valid  = (cmd == CMD_LOAD) || (cmd == CMD_ERASE) || (cmd == CMD_WRITE) ||
                        (cmd == CMD_FUSE) || (cmd == CMD_CLEAR);
    assign seq_busy   = (state_reg == SEQ_ERASE) || (state_reg == SEQ_WRITE);
    assign ctrl_accept = ctrl_write && cmd_valid && !eeprom_write_busy && !seq_busy;
    assign buf_index  = pointer_pair[WORD_LSB +: WORD_W];
    assign ptr_page   = pointer_pair[PAGE_LSB +: PAGE_W];

    // Sequencer next state
    always_comb begin
        state_next       = state_reg;
        ctrl_next        = ctrl_reg;
        window_next      = window_reg;
        page_next        = page_reg;
        buf_load         = 1'b0;
        buf_clear        = 1'b0;
        timer_start      = 1'b0;
        erase_start_next = 1'b0;
        write_start_next = 1'b0;
        if (eeprom_write_busy && buf_any_loaded) begin
            buf_clear = 1'b1;
        end
        // Clear bit acts at the control write, even beside a store
        if (ctrl_accept && cmd == CMD_CLEAR) begin
            buf_clear = 1'b1;
        end
        case (state_reg)
            SEQ_IDLE, SEQ_ARMED: begin
                if (state_reg == SEQ_ARMED && store_program_instruction) begin
                    case (ctrl_reg[4:0])
                        CMD_ERASE: begin
                            page_next        = pointer_pair[PAGE_LSB +: PAGE_W];
                            timer_start      = 1'b1;
                            erase_start_next = 1'b1;
                            state_next       = SEQ_ERASE;
                        end
                        CMD_WRITE: begin
                            page_next        = pointer_pair[PAGE_LSB +: PAGE_W];
                            timer_start      = 1'b1;
                            write_start_next = 1'b1;
                            state_next       = SEQ_WRITE;
                        end
                        CMD_LOAD: begin
                            buf_load   = 1'b1;
                            ctrl_next  = CTRL_RESET;
                            state_next = SEQ_IDLE;
                        end
                        default: begin
                            ctrl_next  = CTRL_RESET;
                            state_next = SEQ_IDLE;
                        end
                    endcase
                end else if (ctrl_accept) begin
                    ctrl_next   = {3'h0, cmd};
                    window_next = WINDOW_LOAD;
                    state_next  = SEQ_ARMED;
                end else if (state_reg == SEQ_ARMED) begin
                    if (window_reg == 3'h1) begin
                        ctrl_next  = CTRL_RESET;
                        state_next = SEQ_IDLE;
                    end else begin
                        window_next = window_reg - 3'h1;
                    end
                end
            end
            SEQ_ERASE, SEQ_WRITE: begin
                if (timer_done) begin
                    ctrl_next  = CTRL_RESET;
                    state_next = SEQ_IDLE;
                    if (state_reg == SEQ_WRITE) begin
                        buf_clear = 1'b1;
                    end
                end
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
        halt_next = (state_next == SEQ_ERASE) || (state_next == SEQ_WRITE);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg       <= SEQ_IDLE;
            ctrl_reg        <= CTRL_RESET;
            window_reg      <= 3'h0;
            page_reg        <= '0;
            halt_reg        <= 1'b0;
            erase_start_reg <= 1'b0;
            write_start_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            ctrl_reg        <= ctrl_next;
            window_reg      <= window_next;
            page_reg        <= page_next;
            halt_reg        <= halt_next;
            erase_start_reg <= erase_start_next;
            write_start_reg <= write_start_next;
        end
    end

    // Temporary page buffer, cleared on reset as well
    fsps_page_buffer u_buffer (
        .clock      (clock),
        .reset      (reset),
        .load       (buf_load),
        .index      (buf_index),
        .data       (data_register_pair),
        .clear      (buf_clear),
        .rd_index   (flash_rd_index),
        .rd_data    (flash_rd_data),
        .any_loaded (buf_any_loaded)
    );

    // Erase and write duration
    fsps_flash_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clock (clock),
        .reset (reset),
        .start (timer_start),
        .done  (timer_done)
    );

    assign avs_readdata      = readdata_reg;
    assign avs_waitrequest   = wait_reg;
    assign core_halt         = halt_reg;
    assign flash_erase_start = erase_start_reg;
    assign flash_write_start = write_start_reg;
    assign flash_page        = page_reg;

    // Checks on the sequencer
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_armed_store(logic [4:0] c);
        state_reg == SEQ_ARMED && store_program_instruction && ctrl_reg[4:0] == c;
    endsequence

    sequence s_quiet_window;
        ctrl_accept ##1 (!store_program_instruction && !ctrl_accept) [*4];
    endsequence

    a_erase_start: assert property (
        s_armed_store(CMD_ERASE) |=> state_reg == SEQ_ERASE && flash_erase_start ##1
            !flash_erase_start)
        else $error("erase did not start after armed store");

    a_erase_page: assert property (
        s_armed_store(CMD_ERASE) |=> flash_page == $past(ptr_page))
        else $error("erase page not taken from page field");

    a_halt_busy: assert property (
        seq_busy |-> core_halt && ctrl_reg[CTRL_ENABLE_BIT])
        else $error("core not halted or enable dropped while busy");

    a_load_word: assert property (
        s_armed_store(CMD_LOAD) |-> buf_load && buf_index == pointer_pair[WORD_LSB +: WORD_W]
            ##1 state_reg == SEQ_IDLE && ctrl_reg == CTRL_RESET)
        else $error("buffer load not performed as commanded");

    a_write_clear: assert property (
        state_reg == SEQ_WRITE && timer_done |-> buf_clear ##1 !core_halt && !seq_busy)
        else $error("page write end did not clear buffer");

    a_eeprom_discard: assert property (
        eeprom_write_busy && buf_any_loaded |-> buf_clear ##1 !buf_any_loaded)
        else $error("loaded words kept during eeprom write");

    a_write_start: assert property (
        s_armed_store(CMD_WRITE) |=> state_reg == SEQ_WRITE && flash_write_start && core_halt)
        else $error("page write did not start after armed store");

    a_halt_until_done: assert property (
        core_halt && !timer_done |=> core_halt)
        else $error("halt released before operation ended");

    a_window_timeout: assert property (
        s_quiet_window |=> state_reg == SEQ_IDLE && !ctrl_reg[CTRL_ENABLE_BIT])
        else $error("enable bit not cleared after four idle cycles");

    a_bad_pattern: assert property (
        ctrl_write && !cmd_valid && state_reg == SEQ_IDLE |=>
            ctrl_reg == $past(ctrl_reg) && state_reg == SEQ_IDLE)
        else $error("undefined command pattern changed the control register");

    a_eeprom_block: assert property (
        ctrl_write && eeprom_write_busy && state_reg == SEQ_IDLE |=> state_reg == SEQ_IDLE)
        else $error("command accepted during eeprom write");

    a_clear_bit: assert property (
        ctrl_accept && cmd == CMD_CLEAR |-> buf_clear ##1 !buf_any_loaded)
        else $error("clear bit did not empty the buffer");
endmodule // fsps_sequencer

/* dv/fsps_core_model.sv */
`timescale 1ns/1ps
// Processor core that issues store instructions when the bench asks
module fsps_core_model
    import fsps_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              core_halt,
    input  wire logic              issue,
    input  wire logic [PTR_W-1:0]  issue_pointer,
    input  wire logic [DATA_W-1:0] issue_data,
    output logic                   store_program_instruction,
    output logic      [PTR_W-1:0]  pointer_pair,
    output logic      [DATA_W-1:0] data_register_pair
);
    // One-cycle store pulse; operands churn every cycle outside it
    always_ff @(posedge clock) begin
        if (reset) begin
            store_program_instruction <= 1'b0;
            pointer_pair              <= 16'h0000;
            data_register_pair        <= 16'h0000;
        end else if (issue && !core_halt) begin
            store_program_instruction <= 1'b1;
            pointer_pair              <= issue_pointer;
            data_register_pair        <= issue_data;
        end else begin
            store_program_instruction <= 1'b0;
            pointer_pair              <= ~pointer_pair;
            data_register_pair        <= ~data_register_pair;
        end
    end
endmodule // fsps_core_model

/* dv/test_fsps_sequencer.sv */
`timescale 1ns/1ps
// Self-checking bench for the self-programming sequencer
module test_fsps_sequencer
    import fsps_pkg::*;
();
    localparam int PROG = 20;
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic [3:0]        avs_address = 4'h0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [3:0]        avs_byteenable = 4'hf;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              store;
    logic [15:0]       pointer;
    logic [15:0]       data;
    logic              eeprom_busy = 1'b0;
    logic              core_halt;
    logic              erase_start;
    logic              write_start;
    logic [6:0]        flash_page;
    logic [4:0]        rd_index = 5'h00;
    logic [15:0]       rd_data;
    logic              issue = 1'b0;
    logic [15:0]       issue_pointer = 16'h0;
    logic [15:0]       issue_data = 16'h0;
    int                failures = 0;
    int                n_tests = 0;
    int                n_erase = 0;
    int                n_write = 0;
    int                halt_len = 0;

    fsps_sequencer #(.PROG_CYCLES(PROG)) fsps_sequencer_inst (
        .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .store_program_instruction(store),
        .pointer_pair(pointer), .data_register_pair(data), .eeprom_write_busy(eeprom_busy),
        .core_halt(core_halt), .flash_erase_start(erase_start),
        .flash_write_start(write_start), .flash_page(flash_page),
        .flash_rd_index(rd_index), .flash_rd_data(rd_data));

    fsps_core_model fsps_core_model_inst (
        .clock(clock), .reset(reset), .core_halt(core_halt), .issue(issue),
        .issue_pointer(issue_pointer), .issue_data(issue_data),
        .store_program_instruction(store), .pointer_pair(pointer),
        .data_register_pair(data));

    // Clock at 10 MHz
    always #50 clock = ~clock;

    // Count start pulses and halted cycles on settled values
    always @(negedge clock) begin
        if (erase_start === 1'b1) n_erase++;
        if (write_start === 1'b1) n_write++;
        if (core_halt === 1'b1) halt_len++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                       input logic [3:0] be, output logic [31:0] rdata);
        @(posedge clock);
        avs_address    <= addr;
        avs_writedata  <= wdata;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] addr, input logic [4:0] cmd);
        logic [31:0] r;
        bus(1'b1, addr, {27'h0, cmd}, 4'hf, r);
    endtask

    task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, addr, 32'h0, 4'hf, r);
        check(r, exp);
    endtask

    // Store k cycles after the last control write; k of at least 2
    task automatic fire(input int k, input logic [15:0] ptr, input logic [15:0] d);
        issue_pointer <= ptr;
        issue_data    <= d;
        repeat (k - 2) @(posedge clock);
        issue <= 1'b1;
        @(posedge clock);
        issue <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic buf_chk(input logic [4:0] idx, input logic [15:0] exp);
        rd_index <= idx;
        repeat (2) @(posedge clock);
        check({16'h0, rd_data}, {16'h0, exp});
    endtask

    // Wait out a halt, then judge its length, page and the control value
    task automatic end_op(input logic [6:0] page);
        while (core_halt !== 1'b0) begin
            @(posedge clock);
        end
        @(posedge clock);
        check(halt_len, PROG + 1);
        check({25'h0, flash_page}, {25'h0, page});
        rd_chk(CTRL_OFFSET, 32'h0);
    endtask

    task automatic t_reset();
        rd_chk(CTRL_OFFSET, {24'h0, CTRL_RESET});
        rd_chk(STATUS_OFFSET, 32'h0);
        buf_chk(5'd0, BUF_CLEAR_WORD);
        wr(STATUS_OFFSET, 5'h1f);
        rd_chk(STATUS_OFFSET, 32'h0);
        rd_chk(4'h8, 32'h0);
        wr(CTRL_OFFSET, CMD_FUSE);
        rd_chk(STATUS_OFFSET, 32'h2);
        rd_chk(CTRL_OFFSET, 32'h0);
    endtask

    task automatic t_load();
        logic [31:0] r;
        bus(1'b1, CTRL_OFFSET, {27'h0, CMD_LOAD}, 4'he, r);
        rd_chk(CTRL_OFFSET, 32'h0);
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(2, {3'b101, 7'h11, 5'd20, 1'b1}, 16'h2014);
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(4, {3'b010, 7'h33, 5'd2, 1'b1}, 16'h0202);
        buf_chk(5'd20, 16'h2014);
        buf_chk(5'd2, 16'h0202);
        rd_chk(STATUS_OFFSET, 32'h4);
        rd_chk(CTRL_OFFSET, 32'h0);
    endtask

    task automatic t_window();
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(5, {10'h0, 5'd4, 1'b0}, 16'h4444);
        buf_chk(5'd4, BUF_CLEAR_WORD);
        rd_chk(CTRL_OFFSET, 32'h0);
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(4, {10'h0, 5'd4, 1'b0}, 16'h4545);
        buf_chk(5'd4, 16'h4545);
    endtask

    task automatic t_undef();
        logic [4:0] pats [4];
        pats = '{5'h07, 5'h0f, 5'h15, 5'h1f};
        foreach (pats[i]) begin
            wr(CTRL_OFFSET, pats[i]);
            rd_chk(CTRL_OFFSET, 32'h0);
            fire(2, {10'h0, 5'd6, 1'b0}, 16'h6666);
            buf_chk(5'd6, BUF_CLEAR_WORD);
        end
    endtask

    task automatic t_clear();
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(2, {10'h0, 5'd9, 1'b0}, 16'h5555);
        buf_chk(5'd9, 16'h5555);
        wr(CTRL_OFFSET, CMD_CLEAR);
        fire(2, {10'h0, 5'd9, 1'b0}, 16'h1111);
        buf_chk(5'd9, BUF_CLEAR_WORD);
        buf_chk(5'd20, BUF_CLEAR_WORD);
        rd_chk(STATUS_OFFSET, 32'h0);
    endtask

    task automatic t_eeprom();
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(2, {10'h0, 5'd7, 1'b0}, 16'habcd);
        rd_chk(STATUS_OFFSET, 32'h4);
        eeprom_busy <= 1'b1;
        @(posedge clock);
        wr(CTRL_OFFSET, CMD_LOAD);
        rd_chk(CTRL_OFFSET, 32'h0);
        rd_chk(STATUS_OFFSET, 32'h8);
        eeprom_busy <= 1'b0;
        buf_chk(5'd7, BUF_CLEAR_WORD);
    endtask

    task automatic t_erase();
        halt_len = 0;
        wr(CTRL_OFFSET, CMD_ERASE);
        fire(3, 16'heabf, 16'h9999);
        rd_chk(CTRL_OFFSET, 32'h3);
        rd_chk(STATUS_OFFSET, 32'h1);
        end_op(7'h2a);
        check(n_erase, 1);
        check(n_write, 0);
    endtask

    task automatic t_write();
        wr(CTRL_OFFSET, CMD_LOAD);
        fire(2, {3'b0, 7'h2a, 5'd3, 1'b0}, 16'h1234);
        buf_chk(5'd3, 16'h1234);
        halt_len = 0;
        wr(CTRL_OFFSET, CMD_WRITE);
        fire(2, 16'h0a80, 16'h7777);
        rd_chk(CTRL_OFFSET, 32'h5);
        end_op(7'h2a);
        check(n_write, 1);
        buf_chk(5'd3, BUF_CLEAR_WORD);
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_reset();
        t_load();
        t_window();
        t_undef();
        t_clear();
        t_eeprom();
        t_erase();
        t_write();
        summarize();
    end
endmodule // test_fsps_sequencer
